/* File: verilog/runaway_watchdog.sv */
// Contract
// - a free-running 13-bit prescaler on the crystal clock carries into a 6-bit watchdog counter.
// - unserviced, the combined count overflows after 2^18 minus 2^4 cycles and requests a reset.
// - a watchdog reset drives the reset pin low for 32 cycles and sets the watchdog cause flag.
// - a service write also clears prescaler bits 12 to 4, leaving the low bits alone.
// - the prescaler is cleared once 4096 cycles have passed after power-up.
// - any internal reset clears both the prescaler and the watchdog counter.
// - a reset vector fetch clears the prescaler.
// - while the disable input is high no watchdog reset is produced.
// - the watchdog runs on the crystal oscillator clock.
// - the watchdog never raises a processor interrupt.
// - the watchdog is disabled in monitor mode when the high test voltage is seen.
// - the watchdog keeps counting in wait standby.
`timescale 1ns/1ps
`include "runaway_watchdog_params.svh"
module runaway_watchdog
	import runaway_watchdog_pkg::*;
#(
	parameter int PRE_W   = `WDG_PRE_WIDTH,
	parameter int CNT_W   = `WDG_CNT_WIDTH,
	parameter int POR_CYC = `WDG_POR_CYCLES
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// avalon-mm slave
	input  wire logic [15:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [7:0]  writedata,
	output logic      [7:0]  readdata,
	output logic             waitrequest,
	// system integration
	input  wire logic        internal_reset,
	input  wire logic        vector_fetch,
	input  wire logic        watchdog_disable,
	input  wire logic        monitor_hv_detect,
	input  wire logic        wait_mode,
	input  wire logic        reset_ack,
	output logic             reset_req,
	output logic             reset_pin_n,
	output logic             reset_pin_oe,
	output logic             cause_flag
);
	// the service clear needs prescaler bits above the kept low bits,
	// and the terminal count is built with 32-bit arithmetic
	if (PRE_W <= `WDG_PRE_CLR_LSB || CNT_W < 1 || POR_CYC < 1 || PRE_W + CNT_W > 31) begin : g_param_check
		$error("runaway_watchdog: unsupported parameters");
	end

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// pin-level inputs only; vector_fetch and reset_ack already live on this clock
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= {watchdog_disable, monitor_hv_detect, internal_reset};
			sync2_r <= sync1_r;
		end
	end
	wire dis_s  = sync2_r[2] | sync2_r[1];
	wire irst_s = sync2_r[0];

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	avmm_req_t req;
	assign req = '{read: read, write: write, address: address, writedata: writedata};
	logic ack_r;
	// one wait state per access, then the answer
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ack_r       <= 1'b0;
			waitrequest <= 1'b1;
		end else begin
			ack_r       <= (req.read | req.write) & ~ack_r;
			// registered inverse of the next ack so the port comes straight from a flip-flop
			waitrequest <= ~((req.read | req.write) & ~ack_r);
		end
	end
	wire svc_wr = req.write & ack_r & (req.address == `WDG_SERVICE_ADDR);
	wire cause_rd = req.read & ack_r & (req.address == `WDG_CAUSE_ADDR);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			readdata <= 8'h00;
		else if ((req.read | req.write) & ~ack_r) begin
			if (req.address == `WDG_SERVICE_ADDR)
				readdata <= `WDG_VECTOR_LOW;
			else if (req.address == `WDG_CAUSE_ADDR)
				readdata <= {7'h00, cause_flag} << `WDG_CAUSE_BIT;
			else
				readdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// power-on delay
	// ----------------------------------------
	logic [$clog2(POR_CYC+1)-1:0] por_cnt_r;
	logic                         por_done_r;
	// runs once after release; later internal resets use their own clear path
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			por_cnt_r  <= '0;
			por_done_r <= 1'b0;
		end else if (!por_done_r) begin
			por_cnt_r  <= por_cnt_r + 1'b1;
			por_done_r <= (por_cnt_r == ($clog2(POR_CYC+1))'(POR_CYC - 1));
		end
	end
	wire por_clr = (por_cnt_r == ($clog2(POR_CYC+1))'(POR_CYC - 1)) & ~por_done_r;

	// ----------------------------------------
	// prescaler and watchdog counter
	// ----------------------------------------
	// crystal clock domain; no wait gating, wait_mode ignored
	logic [PRE_W-1:0] pre_r;
	logic [CNT_W-1:0] cnt_r;
	wdg_state_t       state_r;
	wire pre_carry = &pre_r;
	// terminal count: combined value one short of 2^(PRE_W+CNT_W-1) - 2^4, so the request
	// registers on cycle 2^18 - 2^4; the counter's top bit is reached only while the disable gate holds off the request
	localparam int                 TOTAL_W  = PRE_W + CNT_W;
	localparam logic [TOTAL_W-1:0] TERM_CNT = (TOTAL_W)'((1 << (TOTAL_W - 1)) - (1 << `WDG_PRE_CLR_LSB) - 1);
	wire overflow = ({cnt_r, pre_r} == TERM_CNT);
	// a service write in the terminal cycle wins over the timeout
	wire fire     = overflow & ~dis_s & ~svc_wr;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			pre_r <= '0;
		// internal reset clears / vector fetch clears
		else if (irst_s | vector_fetch | por_clr)
			pre_r <= '0;
		else if (svc_wr)
			pre_r <= {{(PRE_W-`WDG_PRE_CLR_LSB){1'b0}}, pre_r[`WDG_PRE_CLR_LSB-1:0]};
		else
			pre_r <= pre_r + 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			cnt_r <= '0;
		// held at zero through the pulse and the wait for acknowledge
		// internal reset / service clear
		else if (irst_s | svc_wr | state_r != ST_RUN)
			cnt_r <= '0;
		else if (pre_carry)
			cnt_r <= cnt_r + 1'b1;
	end

	// ----------------------------------------
	// reset generation
	// ----------------------------------------
	// limitation: an ack during the pulse drops the request early; ack after the pin returns
	logic [5:0] pulse_r;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_RUN;
			pulse_r <= 6'h00;
		end else begin
			case (state_r)
				ST_RUN: begin
					// overflow / disable gate / service wins
					if (fire) begin
						state_r <= ST_PULSE;
						pulse_r <= 6'h00;
					end
				end
				ST_PULSE: begin
					pulse_r <= pulse_r + 6'h01;
					if (pulse_r == 6'(`WDG_PULSE_CYCLES - 1))
						state_r <= ST_WAIT_ACK;
				end
				default: begin
					if (reset_ack)
						state_r <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reset_req    <= 1'b0;
			reset_pin_n  <= 1'b1;
			reset_pin_oe <= 1'b0;
		end else begin
			reset_req    <= (state_r == ST_RUN) ? fire : ~reset_ack;
			reset_pin_n  <= ~((state_r == ST_RUN) ? fire :
			                  (state_r == ST_PULSE && pulse_r != 6'(`WDG_PULSE_CYCLES - 1)));
			reset_pin_oe <= (state_r == ST_RUN) ? fire :
			                  (state_r == ST_PULSE && pulse_r != 6'(`WDG_PULSE_CYCLES - 1));
		end
	end

	// cause flag; set wins over read clear; no interrupt output exists
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			cause_flag <= 1'b0;
		else if (state_r == ST_RUN && fire)
			cause_flag <= 1'b1;
		else if (cause_rd)
			cause_flag <= 1'b0;
	end
endmodule : runaway_watchdog

/* File: verilog/runaway_watchdog_params.svh */
`ifndef RUNAWAY_WATCHDOG_PARAMS_SVH
`define RUNAWAY_WATCHDOG_PARAMS_SVH
// ----------------------------------------
// register map and timing
// ----------------------------------------
`define WDG_SERVICE_ADDR    16'hffff
`define WDG_CAUSE_ADDR      16'hfe01
`define WDG_CAUSE_BIT       4'h1
`define WDG_PRE_WIDTH       13
`define WDG_CNT_WIDTH       6
`define WDG_PRE_CLR_LSB     4
`define WDG_PULSE_CYCLES    32
`define WDG_POR_CYCLES      4096
`define WDG_CLK_HZ          10000000
`define WDG_VECTOR_LOW      8'h00
`endif

/* File: verilog/runaway_watchdog_pkg.sv */
package runaway_watchdog_pkg;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_RUN,
		ST_PULSE,
		ST_WAIT_ACK
	} wdg_state_t;
	typedef struct packed {
		logic        read;
		logic        write;
		logic [15:0] address;
		logic [7:0]  writedata;
	} avmm_req_t;
endpackage : runaway_watchdog_pkg

/* File: testbench/runaway_watchdog_sva.sv */
`timescale 1ns/1ps
`include "runaway_watchdog_params.svh"
module runaway_watchdog_sva (
	// bus
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        read,
	input wire logic        write,
	input wire logic        waitrequest,
	input wire logic [15:0] address,
	input wire logic [7:0]  readdata,
	// system
	input wire logic        watchdog_disable,
	input wire logic        monitor_hv_detect,
	input wire logic        reset_ack,
	input wire logic        reset_req,
	input wire logic        reset_pin_n,
	input wire logic        reset_pin_oe,
	input wire logic        cause_flag
);
	// ----
	// checks
	// ----
	logic [5:0] low_r;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// saturates so a stuck pin cannot wrap back to a legal count
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			low_r <= '0;
		else if (reset_pin_n)
			low_r <= '0;
		else if (low_r != 6'h3f)
			low_r <= low_r + 6'h01;
	end
	property p_acc; (read || write) && waitrequest |=> !waitrequest; endproperty
	a_acc: assert property (p_acc) else $error("no bus answer");
	property p_vec; read && !waitrequest && address == `WDG_SERVICE_ADDR |-> readdata == `WDG_VECTOR_LOW; endproperty
	a_vec: assert property (p_vec) else $error("bad vector byte");
	property p_len; $rose(reset_pin_n) |-> low_r == `WDG_PULSE_CYCLES; endproperty
	a_len: assert property (p_len) else $error("bad pulse length");
	property p_oe; reset_pin_oe == !reset_pin_n; endproperty
	a_oe: assert property (p_oe) else $error("bad pin enable");
	property p_cause; $fell(reset_pin_n) |-> ##[0:2] cause_flag; endproperty
	a_cause: assert property (p_cause) else $error("cause not set");
	property p_req; $rose(reset_req) |-> ##[0:1] !reset_pin_n; endproperty
	a_req: assert property (p_req) else $error("pin not driven");
	property p_hold; reset_req && !reset_ack && !$past(reset_ack) |=> reset_req; endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_rel; reset_ack && reset_req && reset_pin_n |=> ##[0:1] !reset_req; endproperty
	a_rel: assert property (p_rel) else $error("request stuck");
	property p_dis; (watchdog_disable && $past(watchdog_disable, 3) || monitor_hv_detect
		&& $past(monitor_hv_detect, 3)) && !reset_req |=> !reset_req; endproperty
	a_dis: assert property (p_dis) else $error("reset while disabled");
endmodule : runaway_watchdog_sva
bind runaway_watchdog runaway_watchdog_sva chk (.clk_sys, .rstn, .read, .write, .waitrequest, .address,
	.readdata, .watchdog_disable, .monitor_hv_detect, .reset_ack, .reset_req, .reset_pin_n,
	.reset_pin_oe, .cause_flag);

/* File: testbench/runaway_watchdog_tb.sv */
`timescale 1ns/1ps
`include "runaway_watchdog_params.svh"
module runaway_watchdog_tb
	import runaway_watchdog_pkg::*;
;
	// ----
	// bench
	// ----
	// shrunk counters: a timeout of 2^(PRE+CNT-1) - 2^4 cycles stays near two thousand
	localparam int PRE = 9;
	localparam int CNT = 3;
	localparam int TMO = 2**(PRE + CNT - 1) - 16;
	logic       clk_sys = 0, rstn = 0, irst = 0, vf = 0, dis = 0, hv = 0, wm = 0, ack = 0;
	avmm_req_t  rq = '0;
	logic [7:0] rd, q;
	logic       waitrequest, reset_req, pin_n, oe, cause;
	int         errors = 0, compares = 0, n;
	runaway_watchdog #(.PRE_W(PRE), .CNT_W(CNT), .POR_CYC(16)) uut (
		.clk_sys(clk_sys), .rstn(rstn), .address(rq.address), .read(rq.read), .write(rq.write),
		.writedata(rq.writedata), .readdata(rd), .waitrequest(waitrequest), .internal_reset(irst),
		.vector_fetch(vf), .watchdog_disable(dis), .monitor_hv_detect(hv), .wait_mode(wm),
		.reset_ack(ack), .reset_req(reset_req), .reset_pin_n(pin_n), .reset_pin_oe(oe),
		.cause_flag(cause));
	initial forever #50 clk_sys = ~clk_sys;
	task automatic end_sim;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(string s, logic [7:0] got, logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s exp %h got %h", s, exp, got);
		end
	endtask : chk
	task automatic tick(int k);
		repeat (k) @(posedge clk_sys);
	endtask : tick
	task automatic bus(logic w, logic [15:0] a, logic [7:0] d);
		int i;
		i = 0;
		rq <= '{!w, w, a, d};
		do begin
			tick(1);
			i++;
		end while (waitrequest !== 1'b0 && i < 50);
		if (waitrequest !== 1'b0) begin
			chk("bus_timeout", waitrequest, 8'h00);
			end_sim();
		end
		q = rd;
		rq <= '0;
		tick(1);
	endtask : bus
	task automatic rdchk(string s, logic [15:0] a, logic [7:0] e);
		bus(0, a, 8'h00);
		chk(s, q, e);
	endtask : rdchk
	task automatic wreq(int hi);
		n = 0;
		while (reset_req !== 1'b1 && n < hi) begin
			tick(1);
			n++;
		end
		if (reset_req !== 1'b1) begin
			chk("req_timeout", reset_req, 8'h01);
			end_sim();
		end
	endtask : wreq
	task automatic t_reg;
		rdchk("vector", `WDG_SERVICE_ADDR, `WDG_VECTOR_LOW);
		bus(1, 16'h1234, 8'h5a);
		rdchk("unmapped", 16'h1234, 8'h00);
		rdchk("cause0", `WDG_CAUSE_ADDR, 8'h00);
		$display("t_reg done");
	endtask : t_reg
	task automatic t_svc;
		wm <= 1;
		repeat (4) begin
			tick(1500);
			bus(1, `WDG_SERVICE_ADDR, 8'hff);
		end
		chk("no_req", reset_req, 0);
		wreq(TMO + 8);
		chk("tmo_min", n > TMO - 24, 1);
		chk("fired", reset_req, 1);
		tick(4);
		chk("pin", {pin_n, oe, cause}, 3'b011);
		tick(40);
		chk("held", reset_req, 1);
		ack <= 1;
		tick(1);
		ack <= 0;
		tick(3);
		chk("rel", reset_req, 0);
		rdchk("cause", `WDG_CAUSE_ADDR, 8'h01 << `WDG_CAUSE_BIT);
		rdchk("cause_clr", `WDG_CAUSE_ADDR, 8'h00);
		wm <= 0;
		$display("t_svc done");
	endtask : t_svc
	task automatic t_dis;
		dis <= 1;
		tick(TMO + 300);
		chk("dis", reset_req, 0);
		dis <= 0;
		hv <= 1;
		tick(TMO + 300);
		chk("hv", reset_req, 0);
		bus(1, `WDG_SERVICE_ADDR, 8'h00);
		hv <= 0;
		tick(1400);
		irst <= 1;
		tick(3);
		irst <= 0;
		tick(1500);
		chk("irst", reset_req, 0);
		$display("t_dis done");
	endtask : t_dis
	// fetch late in the period pushes the timeout by the prescaler value
	task automatic t_vf;
		bus(1, `WDG_SERVICE_ADDR, 8'h00);
		tick(1900);
		vf <= 1;
		tick(1);
		vf <= 0;
		tick(200);
		chk("vf", reset_req, 0);
		wreq(2**PRE);
		chk("vf_tmo", reset_req, 1);
		$display("t_vf done");
	endtask : t_vf
	initial begin
		tick(4);
		rstn <= 1;
		tick(1);
		t_reg();
		t_svc();
		t_dis();
		t_vf();
		end_sim();
	end
endmodule : runaway_watchdog_tb
